/* File: sbw_pkg.sv */
package sbw_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;

  localparam logic [5:0] OPCODE_VALUE = 6'h16;
  localparam int unsigned OPC_MSB = 15;
  localparam int unsigned OPC_LSB = 10;
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned BANK_BIT = 8;
  localparam int unsigned FIELD_MSB = 7;

  localparam logic [7:0] ILO_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW_PAGE = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_PAGE = 4'hF;

  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DECODE,
    S_READ,
    S_PROCESS,
    S_WRITE
  } sbw_state_t;
endpackage

/* File: sbw_sub_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module sbw_sub_alu
  import sbw_pkg::*;
(
  input  wire logic [7:0] byte_in,   // addressed byte
  input  wire logic [7:0] acc_in,    // accumulator
  input  wire logic       carry_in,  // carry, inverted borrow
  output logic      [7:0] result,    // difference
  output logic            neg,       // negative
  output logic            ovf,       // signed overflow
  output logic            carry,     // no borrow
  output logic            dcarry,    // no borrow from low nibble
  output logic            zero       // zero result
);
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // byte + ~acc + carry is byte - acc - !carry
  assign full_sum = {1'b0, byte_in} + {1'b0, ~acc_in} + {8'h00, carry_in}; // RULE1
  assign low_sum  = {1'b0, byte_in[3:0]} + {1'b0, ~acc_in[3:0]} + {4'h0, carry_in};
  assign result   = full_sum[7:0];
  assign carry    = full_sum[8]; // RULE8
  assign dcarry   = low_sum[4]; // RULE8
  assign neg      = full_sum[7];
  assign zero     = (full_sum[7:0] == 8'h00);
  assign ovf      = (byte_in[7] != acc_in[7]) && (full_sum[7] != byte_in[7]);
endmodule
`default_nettype wire

/* File: sbw_exec.sv */
// Operation
// [RULE1] result is byte minus accumulator minus not-carry
// [RULE2] destination bit zero writes accumulator only
// [RULE3] destination bit one writes byte back
// [RULE4] bank bit zero uses access bank
// [RULE5] bank bit one uses bank select register
// [RULE6] extended set, low fields use indexed offset
// [RULE7] decode six-bit opcode, d, a, field
// [RULE8] update negative, overflow, carry, digit carry, zero
// [RULE9] four phases: decode, read, process, write
`timescale 1ns/1ps
`default_nettype none
module sbw_exec
  import sbw_pkg::*;
(
  input  wire logic              clk_sys,              // 25 MHz core clock
  input  wire logic              rst_n,                // async reset, active low
  input  wire logic              clk_en,               // freezes all state when low
  input  wire logic              instr_valid,          // instruction word offered
  input  wire logic [15:0]       instr_word,           // program word
  input  wire logic              ext_instr_set_en,     // extended instruction set on
  input  wire logic [BANK_W-1:0] bank_select_register, // bank for banked access
  input  wire logic [ADDR_W-1:0] index_pointer,        // base for indexed offset
  input  wire logic              acc_load_en,          // load accumulator from outside
  input  wire logic [7:0]        acc_load_data,        // value for accumulator load
  input  wire logic              carry_load_en,        // load carry from outside
  input  wire logic              carry_load_data,      // value for carry load
  input  wire logic [7:0]        mem_rd_data,          // data memory read data
  output logic      [ADDR_W-1:0] mem_addr,             // data memory address
  output logic                   mem_rd_en,            // read strobe
  output logic                   mem_wr_en,            // write strobe
  output logic      [7:0]        mem_wr_data,          // write data
  output logic      [7:0]        acc,                  // accumulator
  output logic                   flag_negative,        // negative flag
  output logic                   overflow_flag,        // overflow flag
  output logic                   flag_carry,           // carry flag
  output logic                   digit_carry_flag,     // digit carry flag
  output logic                   flag_zero,            // zero flag
  output logic                   busy,                 // instruction in flight
  output logic                   done                  // one-cycle completion pulse
);
  sbw_state_t        state;
  logic [15:0]       word;
  logic [7:0]        operand;
  logic [7:0]        result;
  logic              res_n;
  logic              res_ov;
  logic              res_c;
  logic              res_dc;
  logic              res_z;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0]        alu_result;
  logic              alu_n;
  logic              alu_ov;
  logic              alu_c;
  logic              alu_dc;
  logic              alu_z;
  logic              opcode_hit;
  logic              dest_bit;
  logic              bank_bit;
  logic [7:0]        field;

  assign opcode_hit = (instr_word[OPC_MSB:OPC_LSB] == OPCODE_VALUE); // RULE7
  assign dest_bit   = word[DEST_BIT]; // RULE7
  assign bank_bit   = word[BANK_BIT]; // RULE7
  assign field      = word[FIELD_MSB:0]; // RULE7

  always_comb
  begin
    next_addr = {ACCESS_LOW_PAGE, field};
    if (bank_bit)
      next_addr = {bank_select_register, field}; // RULE5
    else if (ext_instr_set_en && (field <= ILO_LIMIT))
      next_addr = index_pointer + {ACCESS_LOW_PAGE, field}; // RULE6
    else if (field >= ACCESS_SPLIT)
      next_addr = {ACCESS_HIGH_PAGE, field}; // RULE4
    else
      next_addr = {ACCESS_LOW_PAGE, field}; // RULE4
  end

  sbw_sub_alu u_alu (
    .byte_in  (operand),
    .acc_in   (acc),
    .carry_in (flag_carry),
    .result   (alu_result),
    .neg      (alu_n),
    .ovf      (alu_ov),
    .carry    (alu_c),
    .dcarry   (alu_dc),
    .zero     (alu_z)
  );

  // phase sequencer; other opcodes are left to the rest of the core
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state <= S_IDLE;
    else if (clk_en)
    begin
      case (state)
        S_IDLE:    if (instr_valid && opcode_hit) state <= S_DECODE; // RULE7
        S_DECODE:  state <= S_READ; // RULE9
        S_READ:    state <= S_PROCESS; // RULE9
        S_PROCESS: state <= S_WRITE; // RULE9
        S_WRITE:   state <= S_IDLE; // RULE9
        default:   state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      word <= WORD_RESET;
    else if (clk_en && (state == S_IDLE) && instr_valid && opcode_hit)
      word <= instr_word;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_addr  <= ADDR_RESET;
      mem_rd_en <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_rd_en <= (state == S_DECODE); // RULE9
      if (state == S_DECODE)
        mem_addr <= next_addr;
    end
  end

  // memory answers in the same cycle as the read strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      operand <= ACC_RESET;
    else if (clk_en && (state == S_READ))
      operand <= mem_rd_data; // RULE9
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result <= ACC_RESET;
      res_n  <= 1'b0;
      res_ov <= 1'b0;
      res_c  <= 1'b0;
      res_dc <= 1'b0;
      res_z  <= 1'b0;
    end
    else if (clk_en && (state == S_PROCESS))
    begin
      result <= alu_result; // RULE1
      res_n  <= alu_n;
      res_ov <= alu_ov;
      res_c  <= alu_c;
      res_dc <= alu_dc;
      res_z  <= alu_z;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_en   <= 1'b0;
      mem_wr_data <= ACC_RESET;
    end
    else if (clk_en)
    begin
      mem_wr_en <= (state == S_WRITE) && dest_bit; // RULE3
      if ((state == S_WRITE) && dest_bit)
        mem_wr_data <= result; // RULE3
    end
  end

  // own write wins over an outside load in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      acc <= ACC_RESET;
    else if (clk_en)
    begin
      if ((state == S_WRITE) && !dest_bit)
        acc <= result; // RULE2
      else if (acc_load_en)
        acc <= acc_load_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_negative    <= 1'b0;
      overflow_flag    <= 1'b0;
      flag_carry       <= 1'b0;
      digit_carry_flag <= 1'b0;
      flag_zero        <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == S_WRITE)
      begin
        flag_negative    <= res_n; // RULE8
        overflow_flag    <= res_ov; // RULE8
        flag_carry       <= res_c; // RULE8
        digit_carry_flag <= res_dc; // RULE8
        flag_zero        <= res_z; // RULE8
      end
      else if (carry_load_en)
        flag_carry <= carry_load_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= (state == S_WRITE); // RULE9
      if ((state == S_IDLE) && instr_valid && opcode_hit)
        busy <= 1'b1;
      else if (state == S_WRITE)
        busy <= 1'b0;
    end
  end

  // checks sample only on enabled edges, since state freezes otherwise
  default clocking cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!rst_n);

  sequence s_start;
    (state == S_IDLE) && instr_valid && opcode_hit;
  endsequence

  sequence s_phases;
    (state == S_DECODE) ##1 (state == S_READ) && mem_rd_en ##1 (state == S_PROCESS) ##1 (state == S_WRITE);
  endsequence

  a_four_phase: assert property (s_start |=> s_phases ##1 done && !busy) // RULE9
    else $error("instruction did not run decode, read, process, write");

  a_other_opcode: assert property ((state == S_IDLE) && instr_valid && !opcode_hit |=> (state == S_IDLE) && !busy) // RULE7
    else $error("foreign opcode started execution");

  a_sub_value: assert property ((state == S_PROCESS) |=> // RULE1
      result == 8'($past(operand) - $past(acc) - {7'h00, !$past(flag_carry)}))
    else $error("difference with borrow is wrong");

  a_acc_dest: assert property ((state == S_WRITE) && !dest_bit |=> (acc == $past(result)) && !mem_wr_en) // RULE2
    else $error("accumulator destination not honoured");

  a_mem_dest: assert property ((state == S_WRITE) && dest_bit |=> // RULE3
      mem_wr_en && (mem_wr_data == $past(result))
      && (acc == ($past(acc_load_en) ? $past(acc_load_data) : $past(acc))))
    else $error("byte destination not honoured");

  a_access_bank: assert property ((state == S_DECODE) && !bank_bit // RULE4
      && !(ext_instr_set_en && (field <= ILO_LIMIT)) |=>
      mem_addr == (($past(field) >= ACCESS_SPLIT) ? {ACCESS_HIGH_PAGE, $past(field)} : {ACCESS_LOW_PAGE, $past(field)}))
    else $error("access bank address wrong");

  a_banked_addr: assert property ((state == S_DECODE) && bank_bit |=> // RULE5
      mem_addr == {$past(bank_select_register), $past(field)})
    else $error("banked address wrong");

  a_indexed_addr: assert property ((state == S_DECODE) && !bank_bit // RULE6
      && ext_instr_set_en && (field <= ILO_LIMIT) |=>
      mem_addr == $past(index_pointer + {ACCESS_LOW_PAGE, field}))
    else $error("indexed literal offset address wrong");

  a_flag_update: assert property ((state == S_PROCESS) ##1 (state == S_WRITE) |=> // RULE8
      (flag_carry == ($past(operand, 2) >= ({1'b0, $past(acc, 2)} + {8'h00, !$past(flag_carry, 2)})))
      && (flag_zero == ($past(result) == 8'h00)) && (flag_negative == $past(result[7])))
    else $error("status flags do not match the subtraction");
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
  import sbw_pkg::*;
;
  logic              clk_sys;
  logic              rst_n;
  logic              clk_en;
  logic              instr_valid;
  logic [15:0]       instr_word;
  logic              ext_instr_set_en;
  logic [BANK_W-1:0] bank_select_register;
  logic [ADDR_W-1:0] index_pointer;
  logic              acc_load_en;
  logic [7:0]        acc_load_data;
  logic              carry_load_en;
  logic              carry_load_data;
  logic [7:0]        mem_rd_data;
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_rd_en;
  logic              mem_wr_en;
  logic [7:0]        mem_wr_data;
  logic [7:0]        acc;
  logic              flag_negative;
  logic              overflow_flag;
  logic              flag_carry;
  logic              digit_carry_flag;
  logic              flag_zero;
  logic              busy;
  logic              done;
  int                n_errors;
  int                checks;

  sbw_exec u_sbw_exec (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_instr_set_en(ext_instr_set_en),
    .bank_select_register(bank_select_register), .index_pointer(index_pointer),
    .acc_load_en(acc_load_en), .acc_load_data(acc_load_data), .carry_load_en(carry_load_en),
    .carry_load_data(carry_load_data), .mem_rd_data(mem_rd_data), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .acc(acc),
    .flag_negative(flag_negative), .overflow_flag(overflow_flag), .flag_carry(flag_carry),
    .digit_carry_flag(digit_carry_flag), .flag_zero(flag_zero), .busy(busy), .done(done)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one full instruction: preload acc and carry, offer the word, follow it to done
  task automatic exec(input logic [7:0] w, input logic c, input logic [7:0] m, input logic d,
                      input logic a, input logic [7:0] f, input logic ext, input logic stall);
    logic [8:0]        r9;
    logic [4:0]        r5;
    logic [ADDR_W-1:0] ea;
    int                n;
    r9 = {1'b0, m} - {1'b0, w} - {8'h00, ~c};
    r5 = {1'b0, m[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
    if (a)
      ea = {bank_select_register, f};
    else if (ext && f <= ILO_LIMIT)
      ea = index_pointer + {4'h0, f};
    else if (f >= ACCESS_SPLIT)
      ea = {ACCESS_HIGH_PAGE, f};
    else
      ea = {ACCESS_LOW_PAGE, f};
    @(negedge clk_sys);
    acc_load_en = 1'b1;
    acc_load_data = w;
    carry_load_en = 1'b1;
    carry_load_data = c;
    mem_rd_data = m;
    ext_instr_set_en = ext;
    @(negedge clk_sys);
    acc_load_en = 1'b0;
    carry_load_en = 1'b0;
    instr_valid = 1'b1;
    instr_word = {OPCODE_VALUE, d, a, f};
    @(negedge clk_sys);
    instr_valid = 1'b0;
    n = 1;
    `CHK(busy, 1'b1)
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
      if (n == 2)
      begin
        `CHK(mem_rd_en, 1'b1)
        `CHK(mem_addr, ea)
      end
      // a frozen enable must stretch the instruction by exactly one cycle
      clk_en = !(stall && n == 2);
    end
    `CHK(n, stall ? 6 : 5)
    `CHK(mem_wr_en, d)
    if (d)
    begin
      `CHK(mem_wr_data, r9[7:0])
      `CHK(acc, w)
    end
    else
      `CHK(acc, r9[7:0])
    `CHK(flag_carry, ~r9[8])
    `CHK(digit_carry_flag, ~r5[4])
    `CHK(overflow_flag, (m[7] != w[7]) && (r9[7] != m[7]))
    `CHK(flag_negative, r9[7])
    `CHK(flag_zero, r9[7:0] == 8'h00)
    `CHK(busy, 1'b0)
    @(negedge clk_sys);
    `CHK(done, 1'b0)
    `CHK(mem_wr_en, 1'b0)
  endtask

  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    n_errors = 0;
    checks = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_instr_set_en = 1'b0;
    bank_select_register = 4'h5;
    index_pointer = 12'h3A0;
    acc_load_en = 1'b0;
    acc_load_data = 8'h00;
    carry_load_en = 1'b0;
    carry_load_data = 1'b0;
    mem_rd_data = 8'h00;
    // count rising edges: the clock's first step out of unknown is itself a falling edge
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK(acc, 8'h00)
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
    `CHK(mem_addr, 12'h000)
    $display("test reset finished");
    exec(8'h0D, 1'b1, 8'h19, 1'b1, 1'b0, 8'h20, 1'b0, 1'b0);
    exec(8'h1A, 1'b0, 8'h1B, 1'b0, 1'b0, 8'h21, 1'b0, 1'b0);
    exec(8'h0E, 1'b1, 8'h03, 1'b1, 1'b0, 8'h22, 1'b0, 1'b0);
    exec(8'h01, 1'b1, 8'h80, 1'b0, 1'b1, 8'h90, 1'b0, 1'b0);
    $display("test arithmetic finished");
    exec(8'h10, 1'b1, 8'h40, 1'b1, 1'b0, 8'h5F, 1'b1, 1'b0);
    exec(8'h10, 1'b0, 8'h40, 1'b1, 1'b0, 8'h60, 1'b1, 1'b0);
    exec(8'h33, 1'b1, 8'h22, 1'b0, 1'b0, 8'hA5, 1'b1, 1'b1);
    exec(8'h05, 1'b0, 8'h05, 1'b1, 1'b0, 8'h10, 1'b0, 1'b0);
    exec(8'h05, 1'b1, 8'h05, 1'b1, 1'b1, 8'h10, 1'b1, 1'b0);
    $display("test addressing finished");
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr_word = {OPCODE_VALUE, 2'b10, 8'h30};
    @(negedge clk_sys);
    instr_valid = 1'b0;
    @(negedge clk_sys);
    `CHK(mem_rd_en, 1'b1)
    rst_n = 1'b0;
    @(negedge clk_sys);
    `CHK(busy, 1'b0)
    `CHK(mem_rd_en, 1'b0)
    `CHK(acc, 8'h00)
    rst_n = 1'b1;
    // an aborted instruction must not finish its write after release
    repeat (3) @(negedge clk_sys);
    `CHK(busy, 1'b0)
    `CHK(mem_wr_en, 1'b0)
    `CHK(done, 1'b0)
    $display("test mid-run reset finished");
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr_word = {6'h17, 2'b11, 8'h20};
    repeat (2) @(negedge clk_sys);
    instr_valid = 1'b0;
    `CHK(busy, 1'b0)
    `CHK(mem_rd_en, 1'b0)
    $display("test foreign opcode finished");
    give_verdict();
  end
endmodule
`default_nettype wire
